// ### hw/becsm_pkg.sv
/*
 Package for the extended configuration space register bank: offsets, identity words,
 capability headers and field layouts. Assumes a dword-wide configuration access port.
*/
package becsm_pkg;
  // Access paths
  typedef enum logic [1:0] {
    BECSM_SRC_CFG    = 2'b00,
    BECSM_SRC_EEPROM = 2'b01,
    BECSM_SRC_SMBUS  = 2'b10,
    BECSM_SRC_NONE   = 2'b11
  } becsm_src_e;

  // Region limits (byte offsets)
  localparam logic [11:0] EXT_LO_OFS  = 12'h100;
  localparam logic [11:0] EXT_HI_OFS  = 12'hFFF;

  // Identity (values are arbitrary)
  localparam logic [15:0] MAKER_ID    = 16'h1AB5;
  localparam logic [15:0] PART_ID     = 16'h0C37;
  localparam logic [11:0] ID_OFS      = 12'h000;

  // Error reporting set
  localparam logic [11:0] ERR_HDR_OFS   = 12'h100;
  localparam logic [11:0] FAT_FLG_OFS   = 12'h104;
  localparam logic [11:0] FAT_MSK_OFS   = 12'h108;
  localparam logic [11:0] FAT_SEV_OFS   = 12'h10C;
  localparam logic [11:0] REC_FLG_OFS   = 12'h110;
  localparam logic [11:0] REC_MSK_OFS   = 12'h114;
  localparam logic [11:0] ERR_CTL_OFS   = 12'h118;
  localparam logic [11:0] HLOG_OFS      = 12'h11C;
  localparam logic [11:0] FS_FLG_OFS    = 12'h12C;
  localparam logic [11:0] FS_MSK_OFS    = 12'h130;
  localparam logic [11:0] FS_SEV_OFS    = 12'h134;
  localparam logic [11:0] FS_CTL_OFS    = 12'h138;
  localparam logic [11:0] FS_HLOG_OFS   = 12'h13C;
  // Virtual channel set
  localparam logic [11:0] VC_HDR_OFS    = 12'h150;
  localparam logic [11:0] VC_CAP1_OFS   = 12'h154;
  localparam logic [11:0] VC_CAP2_OFS   = 12'h158;
  localparam logic [11:0] VC_PSC_OFS    = 12'h15C;
  localparam logic [11:0] CH0_CAP_OFS   = 12'h160;
  localparam logic [11:0] CH0_CTL_OFS   = 12'h164;
  localparam logic [11:0] CH0_STA_OFS   = 12'h168;
  // Misc
  localparam logic [11:0] XPIN_OFS      = 12'h300;
  localparam logic [11:0] XIO_OFS       = 12'h304;
  localparam logic [11:0] RATIM_OFS     = 12'h310;

  // Capability headers: id [15:0], version [19:16], next [31:20]
  localparam logic [31:0] ERR_HDR_VAL   = 32'h1501_0001;
  localparam logic [31:0] VC_HDR_VAL    = 32'h0001_0002;
  localparam logic [31:0] VC_CAP1_VAL   = 32'h0000_0000;
  localparam logic [31:0] VC_CAP2_VAL   = 32'h0000_0000;
  localparam logic [31:0] CH0_CAP_VAL   = 32'h0000_0001;

  // Reset values
  localparam logic [31:0] FAT_SEV_RST   = 32'h0006_2030;
  localparam logic [31:0] CH0_CTL_RST   = 32'h8000_00FF;
  localparam logic [31:0] RATIM_RST     = 32'h0000_0000;
  localparam logic [31:0] ZERO_RST      = 32'h0000_0000;
  // Error control: bits [4:0] first error pointer (READ_ONLY_STICKY), bits [8:5] writable
  localparam logic [31:0] ERR_CTL_WMASK = 32'h0000_01E0;
  localparam int          FEP_LSB       = 0;
  // Channel 0 status: bit 1 negotiation pending (RO)
  localparam int          CH0_PEND_BIT  = 1;
endpackage

// ### hw/becsm_regs.sv
/*
 Extended configuration space register bank (100h-FFFh) plus the identity dword at 00h.
 Assumes one dword access per cycle on each path; a single access path is active at a time,
 with config first, then SMBus, then EEPROM. Sticky state clears only on power-on reset.
*/
// Notes on behaviour
// - Decode extended region 100h through FFFh.
// - Error reporting header at 100h, id 0001h.
// - Virtual channel header at 150h, id 0002h.
// - Write-one-clear bits clear only where written 1.
// - Write-one-clear sticky also survives ordinary resets.
// - Read-only sticky ignores writes, survives ordinary resets.
// - Maker code bits 15:0 at 00h, read-only.
// - Part code bits 31:16 at 00h, read-only.
// - Map applies in transparent bridging mode.
// - EEPROM preloads marked registers; of read-only entries only the error header readable.
`timescale 1ns/100ps
module becsm_regs (
  // Clock and resets
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     por,
  // Mode
  input  wire logic                     transparent_mode,
  // Configuration access
  input  wire logic                     cfg_wr,
  input  wire logic                     cfg_rd,
  input  wire logic [11:0]              cfg_addr,
  input  wire logic [31:0]              cfg_wdata,
  input  wire logic [3:0]               cfg_be,
  output logic      [31:0]              cfg_rdata,
  output logic                          cfg_hit,
  // EEPROM preload access
  input  wire logic                     ee_wr,
  input  wire logic                     ee_rd,
  input  wire logic [11:0]              ee_addr,
  input  wire logic [31:0]              ee_wdata,
  output logic      [31:0]              ee_rdata,
  output logic                          ee_hit,
  // SMBus access
  input  wire logic                     smb_wr,
  input  wire logic                     smb_rd,
  input  wire logic [11:0]              smb_addr,
  input  wire logic [31:0]              smb_wdata,
  output logic      [31:0]              smb_rdata,
  output logic                          smb_hit,
  // Error events from the bridge core
  input  wire logic [31:0]              fat_err_set,
  input  wire logic [31:0]              rec_err_set,
  input  wire logic [31:0]              fs_err_set,
  input  wire logic                     hlog_load,
  input  wire logic [127:0]             hlog_data,
  input  wire logic                     fs_hlog_load,
  input  wire logic [127:0]             fs_hlog_data,
  input  wire logic [4:0]               first_err_ptr,
  input  wire logic                     ch0_pending,
  // Extended pins
  input  wire logic [31:0]              xpin_in,
  // Register outputs to core
  output logic      [31:0]              fat_err_mask,
  output logic      [31:0]              rec_err_mask,
  output logic      [31:0]              ch0_ctl,
  output logic      [31:0]              xpin_ctl,
  output logic      [31:0]              retry_ack_timer
);
  import becsm_pkg::*;

  // Selected access: config wins, then SMBus, then EEPROM
  wire logic        acc_cfg  = transparent_mode & (cfg_wr | cfg_rd);
  wire logic        acc_smb  = ~acc_cfg & (smb_wr | smb_rd);
  wire logic        acc_ee   = ~acc_cfg & ~acc_smb & (ee_wr | ee_rd);
  wire becsm_src_e  src      = acc_cfg ? BECSM_SRC_CFG :
                               acc_smb ? BECSM_SRC_SMBUS :
                               acc_ee  ? BECSM_SRC_EEPROM : BECSM_SRC_NONE;
  wire logic [11:0] a        = acc_cfg ? cfg_addr : acc_smb ? smb_addr : ee_addr;
  wire logic [31:0] wraw     = acc_cfg ? cfg_wdata : acc_smb ? smb_wdata : ee_wdata;
  wire logic        wr       = (acc_cfg & cfg_wr) | (acc_smb & smb_wr) | (acc_ee & ee_wr);
  wire logic [11:0] da       = {a[11:2], 2'b00};
  // Byte enables only on the configuration path
  wire logic [31:0] bm       = acc_cfg ? {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                                          {8{cfg_be[1]}}, {8{cfg_be[0]}}} : 32'hFFFF_FFFF;
  wire logic [31:0] w1       = wraw & bm;

  wire logic        in_ext   = (da >= EXT_LO_OFS) && (da <= EXT_HI_OFS);

  // EEPROM may only read the header, error mask and the timer, and preload only the mask and the timer
  wire logic ee_ok  = (da == ERR_HDR_OFS) || (da == FAT_MSK_OFS)
                   || (da == RATIM_OFS);
  wire logic ee_wok = (da == FAT_MSK_OFS) || (da == RATIM_OFS);
  wire logic wen    = wr & in_ext & ((src != BECSM_SRC_EEPROM) | ee_wok);

  wire logic w_fat_flg = wen & (da == FAT_FLG_OFS);
  wire logic w_fat_msk = wen & (da == FAT_MSK_OFS);
  wire logic w_fat_sev = wen & (da == FAT_SEV_OFS);
  wire logic w_rec_flg = wen & (da == REC_FLG_OFS);
  wire logic w_rec_msk = wen & (da == REC_MSK_OFS);
  wire logic w_err_ctl = wen & (da == ERR_CTL_OFS);
  wire logic w_fs_flg  = wen & (da == FS_FLG_OFS);
  wire logic w_fs_msk  = wen & (da == FS_MSK_OFS);
  wire logic w_fs_sev  = wen & (da == FS_SEV_OFS);
  wire logic w_fs_ctl  = wen & (da == FS_CTL_OFS);
  wire logic w_vc_psc  = wen & (da == VC_PSC_OFS);
  wire logic w_ch0_ctl = wen & (da == CH0_CTL_OFS);
  wire logic w_xpin    = wen & (da == XPIN_OFS);
  wire logic w_xio     = wen & (da == XIO_OFS);
  wire logic w_ratim   = wen & (da == RATIM_OFS);

  // Sticky state, cleared by power-on reset only
  logic [31:0]  fat_flg_r, rec_flg_r, fs_flg_r;
  logic [31:0]  fat_sev_r, fs_sev_r, fat_msk_r, rec_msk_r, fs_msk_r;
  logic [31:0]  err_ctl_r, fs_ctl_r;
  logic [127:0] hlog_r, fs_hlog_r;
  // Ordinary state
  logic [31:0]  vc_psc_r, ch0_ctl_r, xpin_r, xio_r, ratim_r;

  // Flag next values: set beats a simultaneous clear
  wire logic [31:0] fat_flg_nxt = (fat_flg_r & ~({32{w_fat_flg}} & w1)) | fat_err_set;
  wire logic [31:0] rec_flg_nxt = (rec_flg_r & ~({32{w_rec_flg}} & w1)) | rec_err_set;
  wire logic [31:0] fs_flg_nxt  = (fs_flg_r  & ~({32{w_fs_flg}}  & w1)) | fs_err_set;
  wire logic [31:0] err_ctl_nxt = w_err_ctl ?
      ((err_ctl_r & ~(ERR_CTL_WMASK & bm)) | (w1 & ERR_CTL_WMASK)) : err_ctl_r;
  wire logic [31:0] err_ctl_cap = {err_ctl_nxt[31:5], first_err_ptr};

  // Masked merge for plain read/write registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [31:0] m);
    merge = (old & ~m) | (d & m);
  endfunction

  always_ff @(posedge clock) begin
    if (por) begin
      fat_flg_r <= ZERO_RST;
      rec_flg_r <= ZERO_RST;
      fs_flg_r  <= ZERO_RST;
      fat_msk_r <= ZERO_RST;
      rec_msk_r <= ZERO_RST;
      fs_msk_r  <= ZERO_RST;
      fat_sev_r <= FAT_SEV_RST;
      fs_sev_r  <= FAT_SEV_RST;
      err_ctl_r <= ZERO_RST;
      fs_ctl_r  <= ZERO_RST;
      hlog_r    <= '0;
      fs_hlog_r <= '0;
    end else begin
      fat_flg_r <= fat_flg_nxt;
      rec_flg_r <= rec_flg_nxt;
      fs_flg_r  <= fs_flg_nxt;
      if (w_fat_msk) fat_msk_r <= merge(fat_msk_r, wraw, bm);
      if (w_rec_msk) rec_msk_r <= merge(rec_msk_r, wraw, bm);
      if (w_fs_msk)  fs_msk_r  <= merge(fs_msk_r, wraw, bm);
      if (w_fat_sev) fat_sev_r <= merge(fat_sev_r, wraw, bm);
      if (w_fs_sev)  fs_sev_r  <= merge(fs_sev_r, wraw, bm);
      if (w_fs_ctl)  fs_ctl_r  <= merge(fs_ctl_r, wraw, bm);
      // First error pointer is captured, never written by software
      if (hlog_load | w_err_ctl) err_ctl_r <= hlog_load ? err_ctl_cap : err_ctl_nxt;
      if (hlog_load)    hlog_r    <= hlog_data;
      if (fs_hlog_load) fs_hlog_r <= fs_hlog_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst | por) begin
      vc_psc_r  <= ZERO_RST;
      ch0_ctl_r <= CH0_CTL_RST;
      xpin_r    <= ZERO_RST;
      xio_r     <= ZERO_RST;
      ratim_r   <= RATIM_RST;
    end else begin
      if (w_vc_psc)  vc_psc_r  <= merge(vc_psc_r, wraw, bm);
      if (w_ch0_ctl) ch0_ctl_r <= merge(ch0_ctl_r, wraw, bm);
      if (w_xpin)    xpin_r    <= merge(xpin_r, wraw, bm);
      if (w_xio)     xio_r     <= merge(xio_r, wraw, bm);
      if (w_ratim)   ratim_r   <= merge(ratim_r, wraw, bm);
    end
  end

  // Header log dword select
  wire logic [1:0]  hl_idx  = 2'(({a[11:2], 2'b00} - HLOG_OFS) >> 2);
  wire logic [1:0]  fhl_idx = 2'(({a[11:2], 2'b00} - FS_HLOG_OFS) >> 2);
  wire logic        in_hl   = (da >= HLOG_OFS) && (da < FS_FLG_OFS);
  wire logic        in_fhl  = (da >= FS_HLOG_OFS) && (da < 12'(FS_HLOG_OFS + 12'h010));

  // Read decode; anything unlisted reads zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (da == ID_OFS) rd_mux = {PART_ID, MAKER_ID};
    else if (in_ext) begin
      if (in_hl)       rd_mux = hlog_r[32*hl_idx +: 32];
      else if (in_fhl) rd_mux = fs_hlog_r[32*fhl_idx +: 32];
      else begin
        case (da)
          ERR_HDR_OFS: rd_mux = ERR_HDR_VAL;
          FAT_FLG_OFS: rd_mux = fat_flg_r;
          FAT_MSK_OFS: rd_mux = fat_msk_r;
          FAT_SEV_OFS: rd_mux = fat_sev_r;
          REC_FLG_OFS: rd_mux = rec_flg_r;
          REC_MSK_OFS: rd_mux = rec_msk_r;
          ERR_CTL_OFS: rd_mux = err_ctl_r;
          FS_FLG_OFS:  rd_mux = fs_flg_r;
          FS_MSK_OFS:  rd_mux = fs_msk_r;
          FS_SEV_OFS:  rd_mux = fs_sev_r;
          FS_CTL_OFS:  rd_mux = fs_ctl_r;
          VC_HDR_OFS:  rd_mux = VC_HDR_VAL;
          VC_CAP1_OFS: rd_mux = VC_CAP1_VAL;
          VC_CAP2_OFS: rd_mux = VC_CAP2_VAL;
          VC_PSC_OFS:  rd_mux = vc_psc_r;
          CH0_CAP_OFS: rd_mux = CH0_CAP_VAL;
          CH0_CTL_OFS: rd_mux = ch0_ctl_r;
          CH0_STA_OFS: rd_mux = 32'(ch0_pending) << CH0_PEND_BIT;
          XPIN_OFS:    rd_mux = xpin_r;
          XIO_OFS:     rd_mux = (xio_r & 32'hFFFF_0000) | (xpin_in & 32'h0000_FFFF);
          RATIM_OFS:   rd_mux = ratim_r;
          default:     rd_mux = 32'h0000_0000;
        endcase
      end
    end
  end

  wire logic known = (da == ID_OFS) | in_ext;
  wire logic rd    = (acc_cfg & cfg_rd) | (acc_smb & smb_rd) | (acc_ee & ee_rd);
  wire logic ee_rd_ok = (src == BECSM_SRC_EEPROM) & ee_ok;

  // Read data registered one cycle after the access
  logic [31:0] cfg_rdata_r, smb_rdata_r, ee_rdata_r;
  logic        cfg_hit_r, smb_hit_r, ee_hit_r;
  always_ff @(posedge clock) begin
    if (rst | por) begin
      cfg_rdata_r <= ZERO_RST;
      smb_rdata_r <= ZERO_RST;
      ee_rdata_r  <= ZERO_RST;
      cfg_hit_r   <= 1'b0;
      smb_hit_r   <= 1'b0;
      ee_hit_r    <= 1'b0;
    end else begin
      cfg_hit_r <= acc_cfg & known;
      smb_hit_r <= acc_smb & known;
      ee_hit_r  <= acc_ee & ee_ok;
      if (rd & (src == BECSM_SRC_CFG))   cfg_rdata_r <= rd_mux;
      if (rd & (src == BECSM_SRC_SMBUS)) smb_rdata_r <= rd_mux;
      if (rd & ee_rd_ok)                 ee_rdata_r  <= rd_mux;
    end
  end

  assign cfg_rdata       = cfg_rdata_r;
  assign smb_rdata       = smb_rdata_r;
  assign ee_rdata        = ee_rdata_r;
  assign cfg_hit         = cfg_hit_r;
  assign smb_hit         = smb_hit_r;
  assign ee_hit          = ee_hit_r;
  assign fat_err_mask    = fat_msk_r;
  assign rec_err_mask    = rec_msk_r;
  assign ch0_ctl         = ch0_ctl_r;
  assign xpin_ctl        = xpin_r;
  assign retry_ack_timer = ratim_r;
endmodule // becsm_regs

// ### testbench/becsm_regs_props.sv
/*
 Checker for the extended configuration register bank, watching its ports only.
 Assumes it is bound onto becsm_regs and that one access path is taken per cycle.
*/
`timescale 1ns/100ps
module becsm_regs_props
  import becsm_pkg::*;
(
  // Clock, resets and mode
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        por,
  input wire logic        transparent_mode,
  // Access paths
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_hit,
  input wire logic        ee_rd,
  input wire logic [11:0] ee_addr,
  input wire logic        ee_hit,
  input wire logic        smb_wr,
  input wire logic        smb_rd,
  input wire logic [11:0] smb_addr,
  input wire logic [31:0] smb_rdata
);
  // Which path wins the cycle
  wire cfg_go = transparent_mode && (cfg_wr || cfg_rd);
  wire smb_go = !cfg_go && (smb_wr || smb_rd);
  wire ee_go  = !cfg_go && !smb_go && ee_rd;
  wire id_rd  = cfg_rd && transparent_mode && cfg_addr[11:2] == ID_OFS[11:2];

  default clocking @(posedge clock); endclocking
  default disable iff (rst || por);

  a_maker_code_read:
    assert property (id_rd |=> cfg_hit && cfg_rdata[15:0] == MAKER_ID) else $error("maker code");
  a_part_code_read:
    assert property (id_rd |=> cfg_rdata[31:16] == PART_ID) else $error("part code");
  a_ext_region_hit:
    assert property (cfg_go && cfg_addr >= EXT_LO_OFS |=> cfg_hit) else $error("no ext hit");
  a_low_header_miss:
    assert property (cfg_go && cfg_addr[11:8] == 4'h0 && cfg_addr[7:2] != 6'h00 |=> !cfg_hit)
      else $error("header hit");
  a_hit_needs_access:
    assert property (!cfg_go |=> !cfg_hit) else $error("stray hit");
  a_error_cap_header:
    assert property (smb_go && smb_rd && smb_addr[11:2] == ERR_HDR_OFS[11:2]
      |=> smb_rdata == ERR_HDR_VAL) else $error("error header");
  a_channel_cap_header:
    assert property (smb_go && smb_rd && smb_addr[11:2] == VC_HDR_OFS[11:2]
      |=> smb_rdata == VC_HDR_VAL) else $error("channel header");
  a_reserved_reads_zero:
    assert property (smb_go && smb_rd && smb_addr >= 12'h170 && smb_addr <= 12'h2FF
      |=> smb_rdata == ZERO_RST) else $error("reserved not zero");
  a_mode_gates_cfg:
    assert property ((cfg_wr || cfg_rd) && !transparent_mode |=> !cfg_hit) else $error("mode");
  a_ee_error_refused:
    assert property (ee_go && ee_addr[11:2] == FAT_FLG_OFS[11:2] |=> !ee_hit) else $error("ee hit");
  a_ee_preload_hit:
    assert property (ee_go && ee_addr[11:2] == FAT_MSK_OFS[11:2] |=> ee_hit) else $error("ee miss");
endmodule // becsm_regs_props

bind becsm_regs becsm_regs_props becsm_regs_props_inst (.*);

// ### testbench/becsm_host.sv
/*
 Host model issuing dword accesses on the configuration, EEPROM and SMBus paths.
 Assumes the bank answers on the edge that takes the request; answers are sampled at the next falling edge.
*/
`timescale 1ns/100ps
module becsm_host
  import becsm_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Requests, one bit per path
  output logic      [2:0]  acc_wr,
  output logic      [2:0]  acc_rd,
  output logic      [11:0] acc_addr,
  output logic      [31:0] acc_wdata,
  output logic      [3:0]  cfg_be,
  // Answers
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_hit,
  input  wire logic [31:0] ee_rdata,
  input  wire logic        ee_hit,
  input  wire logic [31:0] smb_rdata,
  input  wire logic        smb_hit
);
  initial begin
    acc_wr = 3'h0;
    acc_rd = 3'h0;
    acc_addr = 12'h000;
    acc_wdata = 32'h0000_0000;
    cfg_be = 4'hF;
  end

  // Byte enables for later configuration writes, changed on a rising edge
  task automatic set_be(input logic [3:0] b);
    @(posedge clock);
    cfg_be <= b;
  endtask

  task automatic acc(input becsm_src_e s, input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r, output logic h);
    @(posedge clock);
    acc_wr[s] <= w;
    acc_rd[s] <= !w;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge clock);
    acc_wr <= 3'h0;
    acc_rd <= 3'h0;
    // Released lines show the inverse so stale values never look valid
    acc_addr <= ~a;
    acc_wdata <= ~d;
    @(negedge clock);
    r = s == BECSM_SRC_CFG ? cfg_rdata : s == BECSM_SRC_SMBUS ? smb_rdata : ee_rdata;
    h = s == BECSM_SRC_CFG ? cfg_hit : s == BECSM_SRC_SMBUS ? smb_hit : ee_hit;
  endtask
endmodule // becsm_host

// ### testbench/tb.sv
/*
 Top testbench for the register bank: resets, then accesses on every path.
 Assumes the host model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
module tb;
  import becsm_pkg::*;
  logic         clock, rst, por, transparent_mode, hlog_load, ch0_pending;
  logic [31:0]  fat_err_set, rec_err_set, fs_err_set, xpin_in, acc_wdata;
  logic [31:0]  cfg_rdata, ee_rdata, smb_rdata;
  logic [11:0]  rsv_ofs [4] = '{12'h170, 12'h2FC, 12'h308, 12'h314};
  logic [31:0]  fat_err_mask, rec_err_mask, ch0_ctl, xpin_ctl, retry_ack_timer;
  logic [127:0] hlog_data;
  logic [11:0]  acc_addr;
  logic [4:0]   first_err_ptr;
  logic [3:0]   cfg_be;
  logic [2:0]   acc_wr, acc_rd;
  logic         cfg_hit, ee_hit, smb_hit;
  int           fails, check_count;

  becsm_host becsm_host_inst (.*);
  becsm_regs becsm_regs_inst (.*,
    .cfg_wr(acc_wr[0]), .cfg_rd(acc_rd[0]), .cfg_addr(acc_addr), .cfg_wdata(acc_wdata),
    .ee_wr(acc_wr[1]), .ee_rd(acc_rd[1]), .ee_addr(acc_addr), .ee_wdata(acc_wdata),
    .smb_wr(acc_wr[2]), .smb_rd(acc_rd[2]), .smb_addr(acc_addr), .smb_wdata(acc_wdata),
    .fs_hlog_load(hlog_load), .fs_hlog_data(~hlog_data));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_hit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t hit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input becsm_src_e s, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        h;
    becsm_host_inst.acc(s, 1'b1, a, d, r, h);
  endtask

  task automatic rdc(input becsm_src_e s, input logic [11:0] a, input logic [31:0] e,
                     input logic eh);
    logic [31:0] r;
    logic        h;
    becsm_host_inst.acc(s, 1'b0, a, 32'h0000_0000, r, h);
    chk_data(r, e);
    chk_hit(h, eh);
  endtask

  task automatic do_reset(input logic p);
    @(posedge clock);
    rst <= 1'b1;
    por <= p;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    por <= 1'b0;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    results;
  end

  initial begin
    rst = 1'b1;
    por = 1'b1;
    transparent_mode = 1'b1;
    hlog_load = 1'b0;
    ch0_pending = 1'b1;
    fat_err_set = 32'h0000_0000;
    rec_err_set = 32'h0000_0000;
    fs_err_set = 32'h0000_0000;
    xpin_in = 32'h0000_5A3C;
    hlog_data = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
    first_err_ptr = 5'h0A;
    do_reset(1'b1);
    chk_data(ch0_ctl, CH0_CTL_RST);
    wr(BECSM_SRC_CFG, ID_OFS, 32'hFFFF_FFFF);
    rdc(BECSM_SRC_CFG, ID_OFS, {PART_ID, MAKER_ID}, 1'b1);
    rdc(BECSM_SRC_CFG, ERR_HDR_OFS, ERR_HDR_VAL, 1'b1);
    rdc(BECSM_SRC_CFG, VC_HDR_OFS, VC_HDR_VAL, 1'b1);
    rdc(BECSM_SRC_CFG, 12'h0FC, ZERO_RST, 1'b0);
    rdc(BECSM_SRC_CFG, 12'hFFC, ZERO_RST, 1'b1);
    foreach (rsv_ofs[i]) begin
      wr(BECSM_SRC_SMBUS, rsv_ofs[i], 32'hFFFF_FFFF);
      rdc(BECSM_SRC_CFG, rsv_ofs[i], ZERO_RST, 1'b1);
      rdc(BECSM_SRC_SMBUS, rsv_ofs[i], ZERO_RST, 1'b1);
    end
    @(posedge clock);
    transparent_mode <= 1'b0;
    rdc(BECSM_SRC_CFG, ERR_HDR_OFS, ZERO_RST, 1'b0);
    rdc(BECSM_SRC_SMBUS, ERR_HDR_OFS, ERR_HDR_VAL, 1'b1);
    rdc(BECSM_SRC_SMBUS, VC_HDR_OFS, VC_HDR_VAL, 1'b1);
    @(posedge clock);
    transparent_mode <= 1'b1;
    rec_err_set <= 32'h0000_0009;
    fat_err_set <= 32'h0000_0010;
    fs_err_set <= 32'h0000_0006;
    hlog_load <= 1'b1;
    @(posedge clock);
    rec_err_set <= 32'h0000_0000;
    fat_err_set <= 32'h0000_0000;
    fs_err_set <= 32'h0000_0004;
    hlog_load <= 1'b0;
    rdc(BECSM_SRC_SMBUS, REC_FLG_OFS, 32'h0000_0009, 1'b1);
    wr(BECSM_SRC_SMBUS, REC_FLG_OFS, 32'h0000_0001);
    rdc(BECSM_SRC_SMBUS, REC_FLG_OFS, 32'h0000_0008, 1'b1);
    // Bit 2 keeps being set while it is cleared: the set must win
    rdc(BECSM_SRC_SMBUS, FS_FLG_OFS, 32'h0000_0006, 1'b1);
    wr(BECSM_SRC_SMBUS, FS_FLG_OFS, 32'h0000_0006);
    rdc(BECSM_SRC_SMBUS, FS_FLG_OFS, 32'h0000_0004, 1'b1);
    @(posedge clock);
    fs_err_set <= 32'h0000_0000;
    wr(BECSM_SRC_SMBUS, FS_FLG_OFS, 32'h0000_0004);
    rdc(BECSM_SRC_SMBUS, FS_FLG_OFS, ZERO_RST, 1'b1);
    rdc(BECSM_SRC_SMBUS, CH0_STA_OFS, 32'h0000_0002, 1'b1);
    wr(BECSM_SRC_SMBUS, XPIN_OFS, 32'h0000_00A5);
    chk_data(xpin_ctl, 32'h0000_00A5);
    wr(BECSM_SRC_SMBUS, XIO_OFS, 32'hFFFF_FFFF);
    rdc(BECSM_SRC_SMBUS, XIO_OFS, 32'hFFFF_5A3C, 1'b1);
    wr(BECSM_SRC_SMBUS, REC_MSK_OFS, 32'h0000_3001);
    chk_data(rec_err_mask, 32'h0000_3001);
    becsm_host_inst.set_be(4'h3);
    wr(BECSM_SRC_CFG, CH0_CTL_OFS, 32'h1234_5678);
    chk_data(ch0_ctl, 32'h8000_5678);
    becsm_host_inst.set_be(4'hF);
    wr(BECSM_SRC_SMBUS, ERR_CTL_OFS, 32'hFFFF_FFFF);
    wr(BECSM_SRC_EEPROM, RATIM_OFS, 32'h0000_1234);
    rdc(BECSM_SRC_EEPROM, RATIM_OFS, 32'h0000_1234, 1'b1);
    chk_data(retry_ack_timer, 32'h0000_1234);
    do_reset(1'b0);
    chk_data(retry_ack_timer, RATIM_RST);
    chk_data(ch0_ctl, CH0_CTL_RST);
    chk_data(xpin_ctl, ZERO_RST);
    chk_data(rec_err_mask, 32'h0000_3001);
    rdc(BECSM_SRC_SMBUS, FS_HLOG_OFS, 32'hEEEE_EEEE, 1'b1);
    rdc(BECSM_SRC_SMBUS, FAT_FLG_OFS, 32'h0000_0010, 1'b1);
    rdc(BECSM_SRC_SMBUS, REC_FLG_OFS, 32'h0000_0008, 1'b1);
    rdc(BECSM_SRC_SMBUS, ERR_CTL_OFS, ERR_CTL_WMASK | 32'h0000_000A, 1'b1);
    rdc(BECSM_SRC_SMBUS, HLOG_OFS, 32'h1111_1111, 1'b1);
    rdc(BECSM_SRC_SMBUS, HLOG_OFS + 12'h00C, 32'h4444_4444, 1'b1);
    wr(BECSM_SRC_EEPROM, FAT_MSK_OFS, 32'h0000_0F0F);
    rdc(BECSM_SRC_EEPROM, FAT_MSK_OFS, 32'h0000_0F0F, 1'b1);
    chk_data(fat_err_mask, 32'h0000_0F0F);
    wr(BECSM_SRC_EEPROM, FAT_SEV_OFS, 32'hFFFF_FFFF);
    rdc(BECSM_SRC_EEPROM, FAT_FLG_OFS, 32'h0000_0F0F, 1'b0);
    rdc(BECSM_SRC_SMBUS, FAT_SEV_OFS, FAT_SEV_RST, 1'b1);
    wr(BECSM_SRC_EEPROM, ERR_HDR_OFS, 32'h0000_0000);
    rdc(BECSM_SRC_EEPROM, ERR_HDR_OFS, ERR_HDR_VAL, 1'b1);
    wr(BECSM_SRC_SMBUS, FAT_MSK_OFS, 32'h00FF_0000);
    chk_data(fat_err_mask, 32'h00FF_0000);
    do_reset(1'b1);
    rdc(BECSM_SRC_SMBUS, FAT_FLG_OFS, ZERO_RST, 1'b1);
    rdc(BECSM_SRC_SMBUS, ERR_CTL_OFS, ZERO_RST, 1'b1);
    results;
  end
endmodule // tb
